// file: logic/psd_consts.svh
// constants for the paged register decoder: addresses, pages, reset values
`ifndef PSD_CONSTS_SVH
`define PSD_CONSTS_SVH
// ==========================================================
// address space and page selector
`define PSD_SPACE_LO        8'h80
`define PSD_PAGE_SEL_ADDR   8'ha7
`define PSD_PAGE_SEL_RESET  8'h00
`define PSD_PAGE_0          8'h00
`define PSD_PAGE_F          8'h0f
`define PSD_BIT_LOW_MASK    3'h0
// ==========================================================
// shared addresses that differ per page
`define PSD_ADDR_PWR_ACC    8'hba
`define PSD_ADDR_TRK_LOW    8'hbd
`define PSD_ADDR_P0_DRV     8'ha4
`define PSD_ADDR_CRC_DATA   8'h91
`define PSD_ADDR_CRC_CTRL   8'h92
`define PSD_ADDR_CRC_IN     8'h93
`define PSD_ADDR_CRC_FLIP   8'h95
`define PSD_ADDR_CRC_AUTO   8'h96
`define PSD_ADDR_CRC_CNT    8'h97
// ==========================================================
// addresses present on every page
`define PSD_ADDR_ACC        8'he0
`define PSD_ADDR_B          8'hf0
`define PSD_ADDR_PSW        8'hd0
`define PSD_ADDR_P0         8'h80
`define PSD_ADDR_P1         8'h90
`define PSD_ADDR_P2         8'ha0
`define PSD_ADDR_SP         8'h81
`define PSD_ADDR_DPL        8'h82
`define PSD_ADDR_DPH        8'h83
`define PSD_ADDR_IE         8'ha8
`define PSD_ADDR_CLOCK_SOURCE_SELECT     8'ha9
`define PSD_ADDR_IE_EXT1    8'he6
`define PSD_ADDR_IE_EXT2    8'he7
`endif

// file: logic/psd_pkg.sv
// types for the paged register decoder
package psd_pkg;
    // ==========================================================
    // which view an access is routed to
    typedef enum logic [2:0] {
        PSD_TGT_NONE   = 3'b001,
        PSD_TGT_PAGED  = 3'b010,
        PSD_TGT_COMMON = 3'b100
    } psd_target_e;

    // one decoded access toward the peripherals
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic       wr;
        logic       rd;
        logic       bit_ok;
    } psd_access_s;
endpackage

// file: logic/psd_decoder.sv
// paged decoder for the direct register space 0x80..0xff
`timescale 1ns/100ps
`include "psd_consts.svh"

module psd_decoder (
    input  wire logic             SYS_CLK,
    input  wire logic             RST_N,
    input  wire logic             DIRECT_EN,
    input  wire logic [7:0]       ADDR,
    input  wire logic             WR_EN,
    input  wire logic             RD_EN,
    input  wire logic             BIT_OP,
    input  wire logic [7:0]       WR_DATA,
    input  wire logic [7:0]       PERIPH_RD_DATA,
    output logic [7:0]            RD_DATA,
    output logic [7:0]            REGISTER_PAGE_SELECT,
    output psd_pkg::psd_access_s  PERIPH_ACC,
    output psd_pkg::psd_target_e  TARGET,
    output logic                  BIT_REFUSED
);

    // ==========================================================
    // usage notes for whoever wires this to the core
    // - the selector is not saved on interrupt entry: a handler that runs
    //   while page F is selected sees page F, which is why software keeps
    //   interrupts off around its page F work
    // - only pages zero and F are decoded; any other selector value leaves
    //   every paged address unanswered, while the common registers and the
    //   selector stay reachable, so software can always find its way back
    // - the page tag on the access is all that tells two registers at one
    //   address apart; peripherals that share an address must decode it
    // - DIRECT_EN must stay low for indirect accesses to the upper data
    //   memory, which use the same addresses
    // - read data comes one cycle after the strobe, from a flip-flop
    // - a reserved slot reads zero except on page zero, which passes it on; nothing promises that it stays so
    // - a read and a write of the selector in one cycle return the old page
    // - a refused bit operation is dropped and flagged; the core decides what follows

    // ==========================================================
    // internal signals
    // classification of the current access
    logic       in_space;
    logic       sel_hit;
    logic       common_hit;
    logic       paged_hit;
    logic       routed_hit;
    logic       bit_ok;
    logic       width_ok;
    // page selector state
    logic [7:0] page_reg;
    logic [7:0] page_next;
    // read path
    logic [7:0] rd_source;
    logic [7:0] rd_data_reg;

    // ==========================================================
    // decoding helpers
    // registers that look the same from pages zero and F; the selector is
    // listed too, although sel_hit claims its address before this is asked
    function automatic logic is_common(input logic [7:0] a);
        case (a)
            // core registers
            `PSD_ADDR_ACC:       is_common = 1'b1;
            `PSD_ADDR_B:         is_common = 1'b1;
            `PSD_ADDR_PSW:       is_common = 1'b1;
            `PSD_ADDR_P0:        is_common = 1'b1;
            `PSD_ADDR_P1:        is_common = 1'b1;
            `PSD_ADDR_P2:        is_common = 1'b1;
            `PSD_ADDR_SP:        is_common = 1'b1;
            `PSD_ADDR_DPL:       is_common = 1'b1;
            `PSD_ADDR_DPH:       is_common = 1'b1;
            `PSD_ADDR_CLOCK_SOURCE_SELECT:    is_common = 1'b1;
            `PSD_PAGE_SEL_ADDR:  is_common = 1'b1;
            // interrupt enables
            `PSD_ADDR_IE:        is_common = 1'b1;
            `PSD_ADDR_IE_EXT1:   is_common = 1'b1;
            `PSD_ADDR_IE_EXT2:   is_common = 1'b1;
            default:             is_common = 1'b0;
        endcase
    endfunction

    // addresses that page F populates beyond the common set
    function automatic logic is_page_f_reg(input logic [7:0] a);
        case (a)
            // converter power-up and tracking
            `PSD_ADDR_PWR_ACC:   is_page_f_reg = 1'b1;
            `PSD_ADDR_TRK_LOW:   is_page_f_reg = 1'b1;
            // port drive strength
            `PSD_ADDR_P0_DRV:    is_page_f_reg = 1'b1;
            // checksum unit
            `PSD_ADDR_CRC_DATA:  is_page_f_reg = 1'b1;
            `PSD_ADDR_CRC_CTRL:  is_page_f_reg = 1'b1;
            `PSD_ADDR_CRC_IN:    is_page_f_reg = 1'b1;
            `PSD_ADDR_CRC_FLIP:  is_page_f_reg = 1'b1;
            `PSD_ADDR_CRC_AUTO:  is_page_f_reg = 1'b1;
            `PSD_ADDR_CRC_CNT:   is_page_f_reg = 1'b1;
            default:             is_page_f_reg = 1'b0;
        endcase
    endfunction

    // does the selected page own a register at this paged address;
    // page zero is fully populated here, so its undefined slots pass on and
    // stay the software's business; other pages than zero and F own nothing
    function automatic logic page_owns(input logic [7:0] page, input logic [7:0] a);
        if (page == `PSD_PAGE_0) begin
            page_owns = 1'b1;
        end else if (page == `PSD_PAGE_F) begin
            page_owns = is_page_f_reg(a);
        end else begin
            page_owns = 1'b0;
        end
    endfunction

    // ==========================================================
    // address classification; bit 7 set means direct register space
    assign in_space   = DIRECT_EN && ADDR[7];
    // the selector is caught first, on every page, so no page can hide it
    assign sel_hit    = in_space && (ADDR == `PSD_PAGE_SEL_ADDR);
    // common registers are claimed before the page is looked at, so code in
    // the middle of page F work still reaches its stack and accumulator
    assign common_hit = in_space && !sel_hit && is_common(ADDR);
    // the rest of the space is shared out between pages by the selector
    assign paged_hit  = in_space && !sel_hit && !common_hit && page_owns(page_reg, ADDR);
    // both views reach the peripherals; only the page tag differs
    assign routed_hit = paged_hit || common_hit;
    // only byte-aligned-to-eight addresses accept single-bit operations
    assign bit_ok     = (ADDR[2:0] == `PSD_BIT_LOW_MASK);
    // a bit operation on a byte-only register must not touch any register
    assign width_ok   = !BIT_OP || bit_ok;

    // ==========================================================
    // page selector register
    // a bit operation on the selector is refused like on any other
    // byte-only register, so the page never changes by halves
    always_comb begin
        page_next = page_reg;
        if (sel_hit && WR_EN && width_ok) begin
            page_next = WR_DATA;
        end
    end

    // reset to page zero; a write lands at this edge, so the next access sees it
    // without any wait; all eight bits are kept so software reads back its write
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            page_reg <= `PSD_PAGE_SEL_RESET;
        end else begin
            page_reg <= page_next;
        end
    end

    // ==========================================================
    // access routed to peripherals, tagged with the current page
    // common registers carry page zero, so a peripheral that decodes the page
    // tag sees them the same whatever the selector holds
    always_comb begin
        PERIPH_ACC.addr   = ADDR;
        PERIPH_ACC.page   = common_hit ? `PSD_PAGE_0 : page_reg;
        PERIPH_ACC.wr     = routed_hit && WR_EN && width_ok;
        PERIPH_ACC.rd     = routed_hit && RD_EN && width_ok;
        PERIPH_ACC.bit_ok = bit_ok;
    end

    // target class of the current access; the selector counts as common
    // because it answers the same way on every page
    always_comb begin
        if (paged_hit) begin
            TARGET = psd_pkg::PSD_TGT_PAGED;
        end else if (common_hit || sel_hit) begin
            TARGET = psd_pkg::PSD_TGT_COMMON;
        end else begin
            TARGET = psd_pkg::PSD_TGT_NONE;
        end
    end

    // bit operation on a byte-only register is dropped, not widened;
    // a bit request with no strobe behind it does not raise the flag
    assign BIT_REFUSED = in_space && BIT_OP && !bit_ok && (RD_EN || WR_EN);

    // ==========================================================
    // read data source; reserved slots off page zero read zero, not the last bus value
    always_comb begin
        rd_source = 8'h00;
        if (sel_hit) begin
            rd_source = page_reg;
        end else if (routed_hit) begin
            rd_source = PERIPH_RD_DATA;
        end
    end

    // registered so a long peripheral read path does not add to the core's
    // own input timing; the value stands until the next read in the space
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_reg <= 8'h00;
        end else if (RD_EN && in_space) begin
            rd_data_reg <= rd_source;
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign RD_DATA              = rd_data_reg;
    assign REGISTER_PAGE_SELECT = page_reg;

endmodule // psd_decoder

// file: verif/psd_periph_model.sv
// peripheral side model: answers reads with a value made from address and page
`timescale 1ns/100ps
// ==========================================================
module psd_periph_model (
    input  psd_pkg::psd_access_s acc,
    output logic [7:0]           rd_data
);
    // the page is mixed in so a read routed to the wrong page returns a different byte
    assign rd_data = acc.addr ^ acc.page ^ 8'h5a;
endmodule // psd_periph_model

// file: verif/psd_decoder_checker.sv
// concurrent checks on the paged decoder ports
`timescale 1ns/100ps
// ==========================================================
module psd_decoder_checker (
    input wire logic            SYS_CLK,
    input wire logic            RST_N,
    input wire logic            DIRECT_EN,
    input wire logic [7:0]      ADDR,
    input wire logic            WR_EN,
    input wire logic            RD_EN,
    input wire logic            BIT_OP,
    input wire logic [7:0]      WR_DATA,
    input wire logic [7:0]      PERIPH_RD_DATA,
    input wire logic [7:0]      RD_DATA,
    input wire logic [7:0]      REGISTER_PAGE_SELECT,
    input psd_pkg::psd_access_s PERIPH_ACC,
    input psd_pkg::psd_target_e TARGET,
    input wire logic            BIT_REFUSED
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // a request that the core really makes into the register space
    wire req = DIRECT_EN && ADDR[7] && (RD_EN || WR_EN);
    wire sel = req && ADDR == 8'ha7;
    AST_PAGE_WR: assert property (sel && WR_EN && !BIT_OP |=> REGISTER_PAGE_SELECT == $past(WR_DATA))
        else $error("page write not taken");
    AST_PAGE_HOLD: assert property (!(sel && WR_EN) |=> $stable(REGISTER_PAGE_SELECT))
        else $error("page changed without write");
    AST_RD_DATA: assert property (req && RD_EN && !sel && TARGET != psd_pkg::PSD_TGT_NONE |=>
        RD_DATA == $past(PERIPH_RD_DATA)) else $error("read data lost");
    AST_SEL_READ: assert property (sel && RD_EN |=> RD_DATA == $past(REGISTER_PAGE_SELECT))
        else $error("page selector read wrong");
    AST_PAGED: assert property (TARGET == psd_pkg::PSD_TGT_PAGED |-> PERIPH_ACC.page == REGISTER_PAGE_SELECT)
        else $error("paged access on wrong page");
    AST_COMMON: assert property (req && ADDR inside {8'ha8, 8'he6, 8'he7, 8'he0, 8'h80} |->
        TARGET == psd_pkg::PSD_TGT_COMMON && PERIPH_ACC.page == 8'h00) else $error("common miss");
    AST_BIT_REF: assert property (req && BIT_OP && ADDR[2:0] != 3'h0 |->
        BIT_REFUSED && !PERIPH_ACC.wr && !PERIPH_ACC.rd) else $error("byte-only bit op passed");
    AST_BIT_OK: assert property (req && BIT_OP && ADDR[2:0] == 3'h0 |-> !BIT_REFUSED ##1 1)
        else $error("bit op refused");
    AST_OUT_SPACE: assert property (!ADDR[7] |-> !PERIPH_ACC.wr && !PERIPH_ACC.rd)
        else $error("access outside space");
    COV_PAGE_F: cover property (TARGET == psd_pkg::PSD_TGT_PAGED && REGISTER_PAGE_SELECT == 8'h0f);
    COV_BIT: cover property (BIT_REFUSED);
    COV_BACK: cover property (sel && WR_EN ##1 req && RD_EN);
endmodule // psd_decoder_checker
bind psd_decoder psd_decoder_checker i_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .DIRECT_EN(DIRECT_EN),
    .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN), .BIT_OP(BIT_OP), .WR_DATA(WR_DATA),
    .PERIPH_RD_DATA(PERIPH_RD_DATA), .RD_DATA(RD_DATA), .REGISTER_PAGE_SELECT(REGISTER_PAGE_SELECT),
    .PERIPH_ACC(PERIPH_ACC), .TARGET(TARGET), .BIT_REFUSED(BIT_REFUSED));

// file: verif/psd_decoder_tb.sv
// self-checking bench for the paged register decoder
`timescale 1ns/100ps
// ==========================================================
module psd_decoder_tb;
    logic SYS_CLK = 0, RST_N = 0, DIRECT_EN = 0, WR_EN = 0, RD_EN = 0, BIT_OP = 0, BIT_REFUSED;
    logic [7:0] ADDR = 8'h00, WR_DATA = 8'h00, PERIPH_RD_DATA, RD_DATA, REGISTER_PAGE_SELECT;
    psd_pkg::psd_access_s PERIPH_ACC;
    psd_pkg::psd_target_e TARGET;
    int num_errors = 0, comparisons = 0, cycles = 0;
    logic [7:0] fl [9] = '{8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'h97, 8'ha4, 8'hba, 8'hbd};
    logic [7:0] cl [5] = '{8'ha8, 8'he6, 8'he7, 8'he0, 8'h80};
    psd_decoder i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .DIRECT_EN(DIRECT_EN), .ADDR(ADDR),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .BIT_OP(BIT_OP), .WR_DATA(WR_DATA), .PERIPH_RD_DATA(PERIPH_RD_DATA),
        .RD_DATA(RD_DATA), .REGISTER_PAGE_SELECT(REGISTER_PAGE_SELECT), .PERIPH_ACC(PERIPH_ACC),
        .TARGET(TARGET), .BIT_REFUSED(BIT_REFUSED));
    psd_periph_model i_per (.acc(PERIPH_ACC), .rd_data(PERIPH_RD_DATA));
    initial forever #5 SYS_CLK = ~SYS_CLK;
    // hang guard: the whole run needs well under two hundred cycles
    always @(posedge SYS_CLK) if (++cycles == 2000) begin num_errors++; final_report(); end
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end
    endtask
    // one access cycle, driven at the falling edge and taken at the next rising edge
    task automatic acc(input logic [7:0] a, d, input logic w, r, b);
        @(negedge SYS_CLK);
        {DIRECT_EN, ADDR, WR_DATA, WR_EN, RD_EN, BIT_OP} = {1'b1, a, d, w, r, b};
        #1;
    endtask
    task automatic idle();
        @(negedge SYS_CLK);
        {DIRECT_EN, WR_EN, RD_EN, BIT_OP} = 4'h0;
    endtask
    task automatic rd(input logic [7:0] a, p, input psd_pkg::psd_target_e t);
        acc(a, 8'h00, 0, 1, 0);
        chk("target", {5'h0, t}, {5'h0, TARGET});
        chk("acc_rd", {7'h0, t != psd_pkg::PSD_TGT_NONE}, {7'h0, PERIPH_ACC.rd});
        if (t != psd_pkg::PSD_TGT_NONE) chk("acc_page", p, PERIPH_ACC.page);
        idle();
        chk("rd_data", (t == psd_pkg::PSD_TGT_NONE) ? 8'h00 : a ^ p ^ 8'h5a, RD_DATA);
    endtask
    task automatic t_page_f();
        acc(8'ha7, 8'h0f, 1, 0, 0);
        rd(8'h96, 8'h0f, psd_pkg::PSD_TGT_PAGED);
        foreach (fl[i]) rd(fl[i], 8'h0f, psd_pkg::PSD_TGT_PAGED);
        foreach (cl[i]) rd(cl[i], 8'h00, psd_pkg::PSD_TGT_COMMON);
        rd(8'hc0, 8'h00, psd_pkg::PSD_TGT_NONE);
        acc(8'ha7, 8'h00, 0, 1, 0);
        idle();
        chk("page_read", 8'h0f, RD_DATA);
        acc(8'ha7, 8'h00, 1, 0, 0);
        idle();
        chk("page_back", 8'h00, REGISTER_PAGE_SELECT);
    endtask
    task automatic t_bits();
        acc(8'h81, 8'h01, 1, 0, 1);
        chk("refuse", 8'h01, {7'h0, BIT_REFUSED});
        chk("refuse_wr", 8'h00, {7'h0, PERIPH_ACC.wr});
        acc(8'h80, 8'h01, 1, 0, 1);
        chk("bit_ok", 8'h00, {7'h0, BIT_REFUSED});
        chk("bit_wr", 8'h01, {7'h0, PERIPH_ACC.wr});
        acc(8'ha7, 8'h0f, 1, 0, 1);
        idle();
        chk("page_bit", 8'h00, REGISTER_PAGE_SELECT);
    endtask
    // unknown page decodes nothing paged; a reset in mid-run brings back page zero
    task automatic t_reset();
        acc(8'ha7, 8'h03, 1, 0, 0);
        rd(8'h96, 8'h03, psd_pkg::PSD_TGT_NONE);
        rd(8'ha8, 8'h00, psd_pkg::PSD_TGT_COMMON);
        acc(8'ha7, 8'h0f, 1, 0, 0);
        idle();
        chk("page_pre", 8'h0f, REGISTER_PAGE_SELECT);
        RST_N = 0;
        #1;
        chk("page_async", 8'h00, REGISTER_PAGE_SELECT);
        repeat (2) @(negedge SYS_CLK);
        RST_N = 1;
        rd(8'h96, 8'h00, psd_pkg::PSD_TGT_PAGED);
    endtask
    initial begin
        repeat (12) @(posedge SYS_CLK);
        @(negedge SYS_CLK) RST_N = 1;
        chk("page_reset", 8'h00, REGISTER_PAGE_SELECT);
        rd(8'h96, 8'h00, psd_pkg::PSD_TGT_PAGED);
        rd(8'hba, 8'h00, psd_pkg::PSD_TGT_PAGED);
        t_page_f();
        t_bits();
        t_reset();
        final_report();
    end
    task automatic final_report();
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
endmodule // psd_decoder_tb
